/* common/sac_pkg.sv */
// Shared constants, types and address decode for the converter control block
package sac_pkg;
  localparam int DATA_W     = 10;
  localparam int CH_W       = 3;
  localparam int PSC_W      = 8;
  localparam int CONV_TICKS = 16;
  localparam int LAT_W      = 14;

  localparam logic [31:0] ADDR_CTRL   = 32'h01D4_0000;
  localparam logic [31:0] ADDR_PSC    = 32'h01D4_0004;
  localparam logic [31:0] ADDR_DAT    = 32'h01D4_0008;
  localparam logic [31:0] BE_HALF_OFS = 32'h0000_0002;
  localparam logic [31:0] BE_BYTE_OFS = 32'h0000_0003;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_RSTART_BIT = 1;
  localparam int CTRL_CH_LSB    = 2;
  localparam int CTRL_CH_MSB    = 4;
  localparam int CTRL_SLEEP_BIT = 5;
  localparam int CTRL_W         = 7;

  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h20;
  localparam logic [PSC_W-1:0]  PSC_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] RES_RESET  = 10'h000;
  localparam logic [DATA_W-1:0] MSB_MASK   = 10'h200;

  typedef enum logic [1:0] {
    SAC_SZ_BYTE = 2'b00,
    SAC_SZ_HALF = 2'b01,
    SAC_SZ_WORD = 2'b10
  } sac_size_t;

  typedef enum logic [1:0] {
    SAC_IDLE  = 2'b00,
    SAC_TRIAL = 2'b01,
    SAC_TAIL  = 2'b11
  } sac_state_t;

  // Big-endian sub-word accesses land on the high end of the word
  function automatic logic sac_match(input logic [31:0] addr, input logic [31:0] base,
                                     input sac_size_t size, input logic big);
    logic [31:0] want;
    want = base;
    if (big && size == SAC_SZ_HALF) want = base + BE_HALF_OFS;
    else if (big && size == SAC_SZ_BYTE) want = base + BE_BYTE_OFS;
    return (addr == want) && (size inside {SAC_SZ_BYTE, SAC_SZ_HALF, SAC_SZ_WORD});
  endfunction : sac_match
endpackage : sac_pkg

/* common/sac_seq_if.sv */
// Signals between the control top, the clock divider and the SAR sequencer
`timescale 1ns/1ps
interface sac_seq_if;
  import sac_pkg::*;
  logic [PSC_W-1:0]  prescale;
  logic              restart;
  logic              tick;
  logic              launch;
  logic              halt;
  logic              cmp_above;
  logic [DATA_W-1:0] dac;
  logic [DATA_W-1:0] result;
  logic              done_pulse;
  logic              busy;

  modport div (input prescale, input restart, output tick);
  modport seq (input tick, input launch, input halt, input cmp_above,
               output dac, output result, output done_pulse, output busy);
endinterface : sac_seq_if

/* core/sac_clkdiv.sv */
// Conversion clock divider: one tick per conversion clock period
`timescale 1ns/1ps
module sac_clkdiv (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Divider control and tick
  sac_seq_if.div   dif
);
  import sac_pkg::*;

  logic [PSC_W:0] cnt_q;
  logic [PSC_W:0] cnt_d;
  logic           tick_q;
  logic           tick_d;
  logic [PSC_W:0] last;

  always_comb begin
    // RULE_05 period two times prescale plus two
    last   = {dif.prescale, 1'b1};
    cnt_d  = cnt_q + 1'b1;
    tick_d = 1'b0;
    // RULE_01 sleep holds divider still
    if (dif.restart) begin
      cnt_d = '0;
    end else if (cnt_q == last) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign dif.tick = tick_q;

  // Helper: cycles since the previous tick
  logic [PSC_W+1:0] gap_q;
  logic             seen_q;
  always_ff @(posedge clk_sys) begin
    if (!resetn || dif.restart || tick_q) gap_q <= '0;
    else gap_q <= gap_q + 1'b1;
    if (!resetn || dif.restart || $changed(dif.prescale)) seen_q <= 1'b0;
    else if (tick_q) seen_q <= 1'b1;
  end

  chk_tick_period: assert property ( // RULE_05
    @(posedge clk_sys) disable iff (!resetn)
    tick_q && seen_q && $stable(dif.prescale) |-> gap_q == {1'b0, dif.prescale, 1'b1})
    else $error("conversion tick period wrong");
endmodule : sac_clkdiv

/* core/sac_sar_seq.sv */
// Successive approximation sequencer: sixteen conversion clocks per result
`timescale 1ns/1ps
module sac_sar_seq (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Sequencer controls and results
  sac_seq_if.seq   sif
);
  import sac_pkg::*;

  sac_state_t        state_q;
  sac_state_t        state_d;
  logic [3:0]        cnt_q;
  logic [3:0]        cnt_d;
  logic [DATA_W-1:0] mask_q;
  logic [DATA_W-1:0] mask_d;
  logic [DATA_W-1:0] dac_q;
  logic [DATA_W-1:0] dac_d;
  logic [DATA_W-1:0] result_q;
  logic [DATA_W-1:0] result_d;
  logic [DATA_W-1:0] keep;
  logic              done;

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    mask_d   = mask_q;
    dac_d    = dac_q;
    result_d = result_q;
    keep     = dac_q;
    done     = 1'b0;
    // RULE_01 sleep aborts, result untouched
    if (sif.halt) begin
      state_d = SAC_IDLE;
    end else if (sif.launch) begin
      // RULE_15 first trial is the MSB
      state_d = SAC_TRIAL;
      cnt_d   = '0;
      mask_d  = MSB_MASK;
      dac_d   = MSB_MASK;
    end else if (sif.tick) begin
      cnt_d = cnt_q + 1'b1;
      unique case (state_q)
        SAC_IDLE: begin
          cnt_d = cnt_q;
        end
        SAC_TRIAL: begin
          // RULE_15 keep bit when input above
          keep   = sif.cmp_above ? dac_q : (dac_q & ~mask_q);
          dac_d  = keep | (mask_q >> 1);
          mask_d = mask_q >> 1;
          if (mask_q[0]) state_d = SAC_TAIL;
        end
        SAC_TAIL: begin
          // RULE_06 store on sixteenth conversion clock
          if (cnt_q == 4'(CONV_TICKS - 1)) begin
            result_d = dac_q;
            done     = 1'b1;
            state_d  = SAC_IDLE;
          end
        end
        default: state_d = SAC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q  <= SAC_IDLE;
      cnt_q    <= '0;
      mask_q   <= '0;
      dac_q    <= '0;
      result_q <= RES_RESET;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      mask_q   <= mask_d;
      dac_q    <= dac_d;
      result_q <= result_d;
    end
  end

  assign sif.dac        = dac_q;
  assign sif.result     = result_q;
  assign sif.done_pulse = done;
  assign sif.busy       = (state_q != SAC_IDLE);

  chk_msb_first: assert property ( // RULE_15
    @(posedge clk_sys) disable iff (!resetn)
    sif.launch && !sif.halt |=> sif.dac == MSB_MASK && state_q == SAC_TRIAL)
    else $error("conversion did not start at the MSB");

  chk_trial_keep: assert property ( // RULE_15
    @(posedge clk_sys) disable iff (!resetn)
    state_q == SAC_TRIAL && sif.tick && !sif.halt && !sif.launch
    |=> ((sif.dac & $past(mask_q)) != '0) == $past(sif.cmp_above))
    else $error("trial bit not decided by comparator");

  chk_result_hold: assert property ( // RULE_02
    @(posedge clk_sys) disable iff (!resetn)
    sif.halt && $past(sif.halt) |-> $stable(result_q))
    else $error("result changed during sleep");
endmodule : sac_sar_seq

/* core/sac_top.sv */
// Converter control top: register port, control state and analogue front-end signals
//
// Behaviour
// RULE_01: Sleep stops conversion clock and conversion.
// RULE_02: Result register holds last value in sleep.
// RULE_03: Reset enters sleep, control reads 0x20.
// RULE_04: Host waits 10ms after leaving sleep.
// RULE_05: Conversion clock is sysclk over 2(prescale+1).
// RULE_06: Conversion takes sixteen conversion clocks.
// RULE_07: Channel field picks input zero to seven.
// RULE_08: Host waits 15us after channel change.
// RULE_09: Start bit launches, then clears itself.
// RULE_10: Start bit clears within one conversion clock.
// RULE_11: Result read launches when start-on-read set.
// RULE_12: Done flag low converting, high after.
// RULE_13: Polling host waits start, done, one period.
// RULE_14: Result register read-only, ten low bits.
// RULE_15: SAR tries MSB first, keeps bit if above.
// RULE_16: Result refuses bytes; others take bytes.
// RULE_17: Big-endian sub-word control addresses offset.
// RULE_18: Done rises only when result stored.
// RULE_19: Done clears on every new launch.
`timescale 1ns/1ps
module sac_top (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      resetn,
  // System bus register port
  input  wire logic                      bus_req,
  input  wire logic                      bus_write,
  input  wire sac_pkg::sac_size_t        bus_size,
  input  wire logic [31:0]               bus_addr,
  input  wire logic [31:0]               bus_wdata,
  input  wire logic                      big_endian,
  output wire logic                      bus_ack,
  output wire logic                      bus_err,
  output wire logic [31:0]               bus_rdata,
  // Analogue front end
  input  wire logic                      cmp_above,
  output wire logic [sac_pkg::CH_W-1:0]  analog_input_sel,
  output wire logic [sac_pkg::DATA_W-1:0] dac_code,
  output wire logic                      conv_clk_en,
  output wire logic                      conv_tick
);
  import sac_pkg::*;

  // Pin synchronisers
  logic [1:0] cmp_sync_q;
  logic [1:0] big_sync_q;
  logic       cmp_s;
  logic       big_s;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cmp_sync_q <= 2'b00;
      big_sync_q <= 2'b00;
    end else begin
      cmp_sync_q <= {cmp_sync_q[0], cmp_above};
      big_sync_q <= {big_sync_q[0], big_endian};
    end
  end

  assign cmp_s = cmp_sync_q[1];
  assign big_s = big_sync_q[1];

  // Control and prescaler state
  logic              start_q, start_d;
  logic              rstart_q, rstart_d;
  logic [CH_W-1:0]   ch_q, ch_d;
  logic              sleep_q, sleep_d;
  logic              done_q, done_d;
  logic [PSC_W-1:0]  psc_q, psc_d;
  logic              clken_q, clken_d;
  logic              ack_q, ack_d;
  logic              err_q, err_d;
  logic [31:0]       rdata_q, rdata_d;

  logic              ctrl_hit, psc_hit, dat_hit, dat_byte;
  logic              ctrl_wr, psc_wr, dat_rd;
  logic              sw_launch, rd_launch, launch;
  logic [CTRL_W-1:0] ctrl_rd;

  sac_seq_if sif ();

  always_comb begin
    // RULE_17 endian-dependent address decode
    ctrl_hit = sac_match(bus_addr, ADDR_CTRL, bus_size, big_s);
    psc_hit  = sac_match(bus_addr, ADDR_PSC, bus_size, big_s);
    // RULE_16 result refuses byte accesses
    dat_byte = sac_match(bus_addr, ADDR_DAT, bus_size, big_s) && bus_size == SAC_SZ_BYTE;
    dat_hit  = sac_match(bus_addr, ADDR_DAT, bus_size, big_s) && bus_size != SAC_SZ_BYTE;
    ctrl_wr  = bus_req && bus_write && ctrl_hit;
    psc_wr   = bus_req && bus_write && psc_hit;
    dat_rd   = bus_req && !bus_write && dat_hit;
    // RULE_09 start bit ignored in start-on-read mode
    sw_launch = start_q && !rstart_q && !sleep_q;
    // RULE_11 result read launches next conversion
    rd_launch = dat_rd && rstart_q && !sleep_q;
    launch    = sw_launch || rd_launch;
  end

  // RULE_12 done flag in bit six
  assign ctrl_rd = {done_q, sleep_q, ch_q, rstart_q, start_q};

  always_comb begin
    start_d  = start_q;
    rstart_d = rstart_q;
    ch_d     = ch_q;
    sleep_d  = sleep_q;
    done_d   = done_q;
    psc_d    = psc_q;
    // RULE_10 cleared in the launch cycle
    if (sw_launch || rstart_q) start_d = 1'b0;
    if (ctrl_wr) begin
      start_d  = bus_wdata[CTRL_START_BIT];
      rstart_d = bus_wdata[CTRL_RSTART_BIT];
      // RULE_07 channel code in binary order
      ch_d     = bus_wdata[CTRL_CH_MSB:CTRL_CH_LSB];
      sleep_d  = bus_wdata[CTRL_SLEEP_BIT];
    end
    // RULE_19 new launch clears done
    if (launch) done_d = 1'b0;
    // RULE_18 done set only on result store
    if (sif.done_pulse) done_d = 1'b1;
    if (psc_wr) psc_d = bus_wdata[PSC_W-1:0];
    // RULE_01 sleep gates the conversion clock
    clken_d = !sleep_d;
  end

  always_comb begin
    ack_d   = bus_req && (ctrl_hit || psc_hit || dat_hit);
    err_d   = bus_req && !(ctrl_hit || psc_hit || dat_hit);
    rdata_d = '0;
    if (bus_req && !bus_write) begin
      if (ctrl_hit) rdata_d = 32'(ctrl_rd);
      else if (psc_hit) rdata_d = 32'(psc_q);
      // RULE_14 read-only result in low bits
      else if (dat_hit) rdata_d = 32'(sif.result);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      // RULE_03 comes up asleep
      {done_q, sleep_q, ch_q, rstart_q, start_q} <= CTRL_RESET;
      psc_q   <= PSC_RESET;
      clken_q <= 1'b0;
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      start_q  <= start_d;
      rstart_q <= rstart_d;
      ch_q     <= ch_d;
      sleep_q  <= sleep_d;
      done_q   <= done_d;
      psc_q    <= psc_d;
      clken_q  <= clken_d;
      ack_q    <= ack_d;
      err_q    <= err_d;
      rdata_q  <= rdata_d;
    end
  end

  // Divider and sequencer wiring
  assign sif.prescale  = psc_q;
  assign sif.restart   = launch || sleep_q;
  assign sif.launch    = launch;
  assign sif.halt      = sleep_q;
  assign sif.cmp_above = cmp_s;

  sac_clkdiv u_div (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .dif     (sif)
  );

  sac_sar_seq u_seq (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .sif     (sif)
  );

  assign bus_ack          = ack_q;
  assign bus_err          = err_q;
  assign bus_rdata        = rdata_q;
  assign analog_input_sel = ch_q;
  assign dac_code         = sif.dac;
  assign conv_clk_en      = clken_q;
  assign conv_tick        = sif.tick;

  // Helper: cycles since the last launch
  logic [LAT_W-1:0] lat_q;
  always_ff @(posedge clk_sys) begin
    if (!resetn || launch) lat_q <= '0;
    else lat_q <= lat_q + 1'b1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  chk_reset_ctrl: assert property ( // RULE_03
    $past(!resetn) |-> ctrl_rd == CTRL_RESET && !conv_clk_en)
    else $error("control not 0x20 after reset");

  chk_sleep_stop: assert property ( // RULE_01
    sleep_q && $past(sleep_q) |-> !conv_tick && !conv_clk_en && !sif.busy)
    else $error("conversion activity during sleep");

  chk_start_clear: assert property ( // RULE_10
    sw_launch && !ctrl_wr |=> !start_q && sif.busy)
    else $error("start bit not cleared at launch");

  chk_read_launch: assert property ( // RULE_11
    dat_rd && rstart_q && !sleep_q |=> sif.busy && !done_q && sif.dac == MSB_MASK)
    else $error("result read did not launch");

  chk_done_low: assert property ( // RULE_19
    launch && !sif.done_pulse |=> !done_q)
    else $error("done not cleared by launch");

  chk_done_store: assert property ( // RULE_18
    $rose(done_q) |-> $past(sif.done_pulse) && $changed(sif.result) || $past(sif.done_pulse))
    else $error("done rose without a stored result");

  chk_busy_done: assert property ( // RULE_12
    sif.busy && !$past(sif.done_pulse) |-> !done_q)
    else $error("done high while converting");

  chk_conv_length: assert property ( // RULE_06
    sif.done_pulse && $stable(psc_q) |-> lat_q == LAT_W'((int'(psc_q) + 1) * 2 * CONV_TICKS))
    else $error("conversion length wrong");

  chk_byte_refuse: assert property ( // RULE_16
    bus_req && dat_byte |=> bus_err && !bus_ack)
    else $error("byte access to result not refused");

  chk_be_ctrl: assert property ( // RULE_17
    bus_req && big_s && bus_size == SAC_SZ_BYTE && bus_addr == ADDR_CTRL + BE_BYTE_OFS |=> bus_ack)
    else $error("big-endian byte control access missed");

  chk_channel_sel: assert property ( // RULE_07
    ctrl_wr |=> analog_input_sel == $past(bus_wdata[CTRL_CH_MSB:CTRL_CH_LSB]))
    else $error("channel select not following control");

  chk_dat_accept: assert property ( // RULE_16
    bus_req && dat_hit |=> bus_ack && !bus_err)
    else $error("halfword or word result access refused");

  chk_byte_accept: assert property ( // RULE_16
    bus_req && (ctrl_hit || psc_hit) && bus_size == SAC_SZ_BYTE |=> bus_ack && !bus_err)
    else $error("byte access to control or prescaler refused");

  chk_result_read: assert property ( // RULE_14
    bus_req && !bus_write && dat_hit |=> bus_rdata == 32'($past(sif.result)))
    else $error("result read returned wrong data");

  chk_result_ro: assert property ( // RULE_14
    $changed(sif.result) |-> $past(sif.done_pulse))
    else $error("result changed without a completed conversion");

  chk_done_rise: assert property ( // RULE_12
    sif.done_pulse |=> done_q)
    else $error("done not set at conversion end");

  chk_done_hold: assert property ( // RULE_12
    done_q && !launch |=> done_q)
    else $error("done dropped without a launch");

  chk_start_ignored: assert property ( // RULE_09
    start_q && rstart_q && !ctrl_wr && !launch && !sif.busy |=> !start_q && !sif.busy)
    else $error("start bit acted in start-on-read mode");

  chk_start_pending: assert property ( // RULE_01
    start_q && !rstart_q && sleep_q && !ctrl_wr |=> start_q && !sif.busy)
    else $error("start acted while asleep");

  chk_clken_sleep: assert property ( // RULE_01
    conv_clk_en != sleep_q)
    else $error("conversion clock enable not tracking sleep");

  chk_launch_tick: assert property ( // RULE_05
    launch |=> !conv_tick)
    else $error("tick right after launch");

  chk_dac_idle: assert property ( // RULE_15
    !sif.busy && !launch |=> $stable(dac_code))
    else $error("trial code moved while idle");

  chk_sel_hold: assert property ( // RULE_07
    !ctrl_wr |=> $stable(analog_input_sel))
    else $error("channel select moved without a write");

  chk_psc_write: assert property ( // RULE_05
    psc_wr |=> sif.prescale == $past(bus_wdata[PSC_W-1:0]))
    else $error("prescaler write not taken");

  chk_sleep_write: assert property ( // RULE_01
    ctrl_wr |=> sleep_q == $past(bus_wdata[CTRL_SLEEP_BIT]))
    else $error("sleep bit write not taken");

  chk_be_base: assert property ( // RULE_17
    bus_req && big_s && bus_size == SAC_SZ_BYTE && bus_addr == ADDR_CTRL |=> bus_err && !bus_ack)
    else $error("big-endian byte access at base accepted");

  chk_be_half: assert property ( // RULE_17
    bus_req && big_s && bus_size == SAC_SZ_HALF && bus_addr == ADDR_CTRL + BE_HALF_OFS |=> bus_ack)
    else $error("big-endian halfword control access missed");

  chk_le_ctrl: assert property ( // RULE_17
    bus_req && !big_s && bus_size == SAC_SZ_BYTE && bus_addr == ADDR_CTRL |=> bus_ack)
    else $error("little-endian byte control access missed");
endmodule : sac_top

/* test/sac_afe_model.sv */
// Analogue front-end stand-in: channel multiplexer and comparator
`timescale 1ns/1ps
module sac_afe_model (
  // Input levels, one code per channel
  input  wire logic [8*sac_pkg::DATA_W-1:0] levels,
  // Front-end pins
  input  wire logic [sac_pkg::CH_W-1:0]     analog_input_sel,
  input  wire logic [sac_pkg::DATA_W-1:0]   dac_code,
  output wire logic                         cmp_above
);
  import sac_pkg::*;
  assign cmp_above = levels[analog_input_sel*DATA_W +: DATA_W] > dac_code;
endmodule : sac_afe_model

/* test/sar_adc_control_tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module sar_adc_control_tb;
  import sac_pkg::*;
  logic clk_sys = 0;
  logic resetn = 0;
  logic bus_req = 0;
  logic bus_write = 0;
  sac_size_t bus_size = SAC_SZ_WORD;
  logic [31:0] bus_addr = 0;
  logic [31:0] bus_wdata = 0;
  logic big_endian = 0;
  logic bus_ack, bus_err, cmp_above, conv_clk_en, conv_tick;
  logic [31:0] bus_rdata, rd, old;
  logic [CH_W-1:0] sel;
  logic [DATA_W-1:0] dac;
  logic [8*DATA_W-1:0] levels = 0;
  logic ak, er;
  int lvl[8];
  int cyc = 0, treq, tick_at = 0, tick_gap = 0, tick_n = 0, p, c0, n;
  int err_total = 0, cmp_count = 0;

  always #5 clk_sys = ~clk_sys;

  sac_top i_dut (.clk_sys(clk_sys), .resetn(resetn), .bus_req(bus_req), .bus_write(bus_write),
    .bus_size(bus_size), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .big_endian(big_endian),
    .bus_ack(bus_ack), .bus_err(bus_err), .bus_rdata(bus_rdata), .cmp_above(cmp_above),
    .analog_input_sel(sel), .dac_code(dac), .conv_clk_en(conv_clk_en), .conv_tick(conv_tick));

  sac_afe_model i_afe (.levels(levels), .analog_input_sel(sel), .dac_code(dac), .cmp_above(cmp_above));

  // Cycle count, tick spacing and run ceiling
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (conv_tick === 1'b1) begin
      tick_gap = cyc - tick_at;
      tick_at = cyc;
      tick_n = tick_n + 1;
    end
    if (cyc == 60000) begin
      err_total = err_total + 1;
      test_done();
    end
  end

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_total = err_total + 1;
    end
  endtask : chk

  // One access: held over the taking edge, answer sampled a cycle later
  task automatic bus(input logic w, input sac_size_t sz, input logic [31:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    bus_req = 1;
    bus_write = w;
    bus_size = sz;
    bus_addr = a;
    bus_wdata = d;
    treq = cyc + 1;
    @(negedge clk_sys);
    bus_req = 0;
    bus_wdata = ~d;
    rd = bus_rdata;
    ak = bus_ack;
    er = bus_err;
  endtask : bus

  task automatic at(input int t);
    while (cyc + 2 < t) @(negedge clk_sys);
  endtask : at

  function automatic logic [31:0] sar_ref(input int v);
    int r;
    r = 0;
    for (int b = 9; b >= 0; b--) begin
      if (v > (r | (1 << b))) r = r | (1 << b);
    end
    return 32'(r);
  endfunction : sar_ref

  task automatic set_lvl(input int ch);
    lvl[ch] = $urandom % 1024;
    @(negedge clk_sys);
    levels[ch*DATA_W +: DATA_W] = lvl[ch][DATA_W-1:0];
  endtask : set_lvl

  task automatic convert(input int ch);
    logic [31:0] cw;
    cw = 32'(ch) << CTRL_CH_LSB;
    bus(1, SAC_SZ_WORD, ADDR_PSC, 32'(p));
    bus(1, SAC_SZ_WORD, ADDR_CTRL, cw);
    repeat (1500) @(negedge clk_sys);
    bus(1, SAC_SZ_BYTE, ADDR_CTRL, cw | 1);
    c0 = treq;
    at(c0 + 2 * p + 2);
    bus(0, SAC_SZ_WORD, ADDR_CTRL, 0);
    chk(rd & 32'h41, 0);
    chk(32'(dac), 32'h200);
    chk(32'(sel), 32'(ch));
    // poll start, then done, then one more period
    at(c0 + 32 * (p + 1) + 2);
    bus(0, SAC_SZ_WORD, ADDR_CTRL, 0);
    chk(rd & 32'h40, 0);
    at(c0 + 32 * (p + 1) + 4);
    bus(0, SAC_SZ_WORD, ADDR_CTRL, 0);
    chk(rd, cw | 32'h40);
    repeat (2 * (p + 1)) @(negedge clk_sys);
    bus(0, SAC_SZ_HALF, ADDR_DAT, 0);
    chk(rd, sar_ref(lvl[ch]));
  endtask : convert

  initial begin
    void'($urandom(38512));
    repeat (4) @(negedge clk_sys);
    resetn = 1;
    bus(0, SAC_SZ_WORD, ADDR_CTRL, 0);
    chk(rd, 32'h20);
    chk(32'(conv_clk_en), 0);
    bus(0, SAC_SZ_WORD, ADDR_PSC, 0);
    chk(rd, 0);
    bus(1, SAC_SZ_BYTE, ADDR_CTRL, 32'h60);
    bus(0, SAC_SZ_WORD, ADDR_CTRL, 0);
    chk(rd, 32'h20);
    bus(1, SAC_SZ_BYTE, ADDR_PSC, 32'hFF);
    bus(0, SAC_SZ_WORD, ADDR_PSC, 0);
    chk(rd, 32'hFF);
    bus(1, SAC_SZ_WORD, ADDR_DAT, 32'h3FF);
    bus(0, SAC_SZ_WORD, ADDR_DAT, 0);
    chk(rd, 0);
    bus(0, SAC_SZ_BYTE, ADDR_DAT, 0);
    chk({30'h0, ak, er}, 1);
    bus(0, SAC_SZ_BYTE, ADDR_PSC, 0);
    chk({30'h0, ak, er}, 2);
    big_endian = 1;
    repeat (3) @(negedge clk_sys);
    bus(0, SAC_SZ_HALF, ADDR_CTRL + BE_HALF_OFS, 0);
    chk({rd[29:0], ak, er}, 32'h82);
    bus(0, SAC_SZ_BYTE, ADDR_CTRL + BE_BYTE_OFS, 0);
    chk({rd[29:0], ak, er}, 32'h82);
    bus(0, SAC_SZ_BYTE, ADDR_CTRL, 0);
    chk({30'h0, ak, er}, 1);
    big_endian = 0;
    repeat (3) @(negedge clk_sys);
    // settle wait shortened: no analogue reference in the model
    bus(1, SAC_SZ_WORD, ADDR_CTRL, 0);
    repeat (2) @(negedge clk_sys);
    chk(32'(conv_clk_en), 1);
    for (int ch = 0; ch < 8; ch++) begin
      p = 2 + $urandom % 4;
      set_lvl(ch);
      convert(ch);
    end
    // Sleep in mid-conversion keeps the old result
    old = sar_ref(lvl[7]);
    set_lvl(7);
    bus(1, SAC_SZ_WORD, ADDR_CTRL, 32'h1D);
    repeat (6 * p + 8) @(negedge clk_sys);
    chk(32'(tick_gap), 32'(2 * (p + 1)));
    bus(1, SAC_SZ_WORD, ADDR_CTRL, 32'h3C);
    repeat (3) @(negedge clk_sys);
    n = tick_n;
    chk(32'(conv_clk_en), 0);
    repeat (40 * (p + 1)) @(negedge clk_sys);
    chk(32'(tick_n), 32'(n));
    bus(0, SAC_SZ_WORD, ADDR_CTRL, 0);
    chk(rd, 32'h3C);
    bus(0, SAC_SZ_WORD, ADDR_DAT, 0);
    chk(rd, old);
    // Start-on-read launches from a result read
    bus(1, SAC_SZ_WORD, ADDR_CTRL, 32'h1E);
    repeat (1500) @(negedge clk_sys);
    bus(0, SAC_SZ_WORD, ADDR_DAT, 0);
    c0 = treq;
    chk(rd, old);
    at(c0 + 32 * (p + 1) + 4);
    bus(1, SAC_SZ_WORD, ADDR_CTRL, 32'h1F);
    at(treq + 3);
    bus(0, SAC_SZ_WORD, ADDR_CTRL, 0);
    chk(rd, 32'h5E);
    bus(0, SAC_SZ_WORD, ADDR_DAT, 0);
    chk(rd, sar_ref(lvl[7]));
    test_done();
  end
endmodule : sar_adc_control_tb
